// ### logic/tcd_pkg.sv
// Purpose: Shared constants and types for the touch control word decoder.
// Assumes: One system clock; the serial clock is sampled as a plain input.
// Notes: Bit positions follow the 8-bit control word, start bit first.
`default_nettype none
package tcd_pkg;
  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int unsigned CW_WIDTH = 8;
  localparam int unsigned START_POS = 7;
  localparam int unsigned CH_HI_POS = 6;
  localparam int unsigned CH_LO_POS = 4;
  localparam int unsigned RES_POS = 3;
  localparam int unsigned REFM_POS = 2;
  localparam int unsigned PM_HI_POS = 1;
  localparam int unsigned PM_LO_POS = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic PM_HI_RST = 1'h1;
  localparam logic PM_LO_RST = 1'h0;
  localparam logic [2:0] CH_RST = 3'h0;
  // ----------------------------------------------------------------
  // Word spacing in serial clock cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] SPACING_12 = 5'hF;
  localparam logic [4:0] SPACING_8 = 5'hB;
  // ----------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_XP = 3'h1;
  localparam logic [2:0] CH_IN3 = 3'h2;
  localparam logic [2:0] CH_YP = 3'h5;
  localparam logic [2:0] CH_IN4 = 3'h6;
  // Identity pattern, value arbitrary.
  localparam logic [11:0] ID_CODE = 12'h5A5;

  typedef enum logic [2:0] {
    MUX_NONE, MUX_XP, MUX_YP, MUX_IN3, MUX_IN4, MUX_ID
  } tcd_mux_t;

  typedef struct packed {
    tcd_mux_t mux;
    logic x_drv;
    logic y_drv;
    logic ref_diff;
  } tcd_route_t;

  typedef struct packed {
    logic [2:0] channel_select_field;
    logic res_8bit;
    logic reference_mode_bit;
    logic power_mode_high_bit;
    logic power_mode_low_bit;
  } tcd_ctrl_t;
endpackage
`default_nettype wire

// ### logic/tcd_route_dec.sv
// Purpose: Decode channel field and reference mode into a route.
// Assumes: Pure combinational, driven from shift register bits only; the incoming bit is not used.
// Notes: Undefined combinations report invalid and a null route.
`default_nettype none
module tcd_route_dec
  import tcd_pkg::*;
(
  // Decoded fields
  input wire logic [2:0] ch_i,
  input wire logic ser_i,
  // Result
  output var tcd_route_t route_o,
  output logic valid_o
);
  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  // Channel and reference mode pick input, drivers and reference.
  always_comb begin
    route_o = '{mux: MUX_NONE, x_drv: 1'b0, y_drv: 1'b0, ref_diff: 1'b0};
    valid_o = 1'b1;
    case ({ch_i, ser_i})
      {CH_XP, 1'b1}: route_o = '{mux: MUX_XP, x_drv: 1'b0, y_drv: 1'b1, ref_diff: 1'b0};
      {CH_IN3, 1'b1}: route_o.mux = MUX_IN3;
      {CH_YP, 1'b1}: route_o = '{mux: MUX_YP, x_drv: 1'b1, y_drv: 1'b0, ref_diff: 1'b0};
      {CH_IN4, 1'b1}: route_o.mux = MUX_IN4;
      {CH_XP, 1'b0}: route_o = '{mux: MUX_XP, x_drv: 1'b0, y_drv: 1'b1, ref_diff: 1'b1};
      {CH_YP, 1'b0}: route_o = '{mux: MUX_YP, x_drv: 1'b1, y_drv: 1'b0, ref_diff: 1'b1};
      {CH_IN4, 1'b0}: route_o = '{mux: MUX_ID, x_drv: 1'b0, y_drv: 1'b0, ref_diff: 1'b1};
      default: valid_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### logic/tcd_decoder.sv
// Purpose: Serial control word decoder of a touch digitizer.
// Assumes: Serial clock and data come from the host and are resampled.
// Notes: The serial clock must stay well below a quarter of MCLK_I.
`default_nettype none
module tcd_decoder
  import tcd_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  // Serial link from host
  input wire logic SERIAL_CONVERSION_CLOCK_I,
  input wire logic SDATA_I,
  input wire logic CS_B_I,
  // Routing outputs
  output var tcd_mux_t MUX_SEL_O,
  output logic X_DRV_O,
  output logic Y_DRV_O,
  output logic REF_DIFF_O,
  // Conversion control outputs
  output logic RES_8BIT_O,
  output logic CONV_START_O,
  output logic CONVERTING_O,
  output logic POWER_DOWN_O,
  output logic TOUCH_DETECT_IRQ_EN_O,
  output logic WORD_LOADED_O
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclk_s_q, sdat_s_q, cs_s_q;
  logic sclk_d1_q;

  // Two flops per pin; stage two feeds logic, and a third serial clock flop feeds edge detection.
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      sclk_s_q <= 2'h0;
      sdat_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      sclk_d1_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], SERIAL_CONVERSION_CLOCK_I};
      sdat_s_q <= {sdat_s_q[0], SDATA_I};
      cs_s_q <= {cs_s_q[0], CS_B_I};
      sclk_d1_q <= sclk_s_q[1];
    end
  end

  // Edge detection on the resampled serial clock.
  wire sel = !cs_s_q[1];
  wire rise = sel && sclk_s_q[1] && !sclk_d1_q;
  wire fall = sel && !sclk_s_q[1] && sclk_d1_q;
  wire sdat = sdat_s_q[1];

  // ----------------------------------------------------------------
  // Word framing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_HUNT, ST_SHIFT, ST_CONV} tcd_state_t;
  tcd_state_t state_q, state_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [6:0] shift_q, shift_d;
  logic [4:0] cyc_q, cyc_d;
  tcd_ctrl_t ctrl_q, ctrl_d;
  tcd_route_t route_q, route_d;
  logic conv_q, conv_d, start_q, start_d, load_q, load_d;

  tcd_route_t dec_route;
  logic dec_valid;
  wire [6:0] word_lo = {shift_q[5:0], sdat};
  wire last_bit = rise && (state_q == ST_SHIFT) && (bit_cnt_q == 3'h6);
  wire [4:0] spacing = ctrl_q.res_8bit ? SPACING_8 : SPACING_12;
  wire conv_end = (state_q == ST_CONV) && rise && (cyc_q == spacing - 5'h9);

  tcd_route_dec u_dec (
    .ch_i(word_lo[6:4]),
    .ser_i(word_lo[2]),
    .route_o(dec_route),
    .valid_o(dec_valid)
  );

  // Next state of the framer and the control word.
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    cyc_d = cyc_q;
    ctrl_d = ctrl_q;
    route_d = route_q;
    conv_d = conv_q;
    start_d = 1'b0;
    load_d = 1'b0;
    if (rise && state_q != ST_SHIFT && sdat) begin
      state_d = ST_SHIFT;
      bit_cnt_d = 3'h0;
      conv_d = 1'b0; // A new word closes any conversion, so an aborted word cannot leave it stuck.
    end else if (rise && state_q == ST_SHIFT) begin
      shift_d = word_lo;
      bit_cnt_d = bit_cnt_q + 3'h1;
      if (last_bit) begin
        if (dec_valid) begin
          ctrl_d = '{channel_select_field: word_lo[6:4], res_8bit: word_lo[3],
                     reference_mode_bit: word_lo[2], power_mode_high_bit: word_lo[1],
                     power_mode_low_bit: word_lo[0]};
          route_d = dec_route;
          state_d = ST_CONV;
          start_d = 1'b1;
          load_d = 1'b1;
          conv_d = 1'b1;
          cyc_d = 5'h0;
        end else begin
          state_d = ST_HUNT;
        end
      end
    end else if (state_q == ST_CONV && rise) begin
      cyc_d = cyc_q + 5'h1;
      if (conv_end) begin
        state_d = ST_HUNT;
        conv_d = 1'b0;
      end
    end
    if (fall && state_q == ST_CONV && cyc_q == 5'h0 && ctrl_q.reference_mode_bit) begin
      route_d.x_drv = 1'b0;
      route_d.y_drv = 1'b0;
    end
    if (!sel && state_q == ST_SHIFT) begin
      state_d = ST_HUNT;
    end
  end

  // Framer registers with power-on defaults.
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      state_q <= ST_HUNT;
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h0;
      cyc_q <= 5'h0;
      ctrl_q <= '{channel_select_field: CH_RST, res_8bit: 1'b0, reference_mode_bit: 1'b1,
                  power_mode_high_bit: PM_HI_RST, power_mode_low_bit: PM_LO_RST};
      route_q <= '{mux: MUX_NONE, x_drv: 1'b0, y_drv: 1'b0, ref_diff: 1'b0};
      conv_q <= 1'b0;
      start_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      cyc_q <= cyc_d;
      ctrl_q <= ctrl_d;
      route_q <= route_d;
      conv_q <= conv_d;
      start_q <= start_d;
      load_q <= load_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Power down only between conversions when the high power bit is clear.
  wire pd_d = !ctrl_d.power_mode_high_bit && !conv_d;
  wire irq_d = !ctrl_d.power_mode_low_bit;
  logic pd_q, irq_q;
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      pd_q <= 1'b0;
      irq_q <= 1'b1;
    end else begin
      pd_q <= pd_d;
      irq_q <= irq_d;
    end
  end

  assign MUX_SEL_O = route_q.mux;
  assign X_DRV_O = route_q.x_drv;
  assign Y_DRV_O = route_q.y_drv;
  assign REF_DIFF_O = route_q.ref_diff;
  assign RES_8BIT_O = ctrl_q.res_8bit;
  assign CONV_START_O = start_q;
  assign CONVERTING_O = conv_q;
  assign POWER_DOWN_O = pd_q;
  assign TOUCH_DETECT_IRQ_EN_O = irq_q;
  assign WORD_LOADED_O = load_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_hunt_no_load: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    state_q == ST_HUNT |=> !load_q)
    else $error("word loaded without start bit");
  chk_start_detect: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (rise && sdat && state_q == ST_HUNT && sel) |=> state_q == ST_SHIFT)
    else $error("start bit missed");
  chk_res_field: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    load_q |-> RES_8BIT_O == $past(word_lo[3], 1))
    else $error("resolution bit wrong");
  chk_ref_mode: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    load_q |-> REF_DIFF_O == !ctrl_q.reference_mode_bit)
    else $error("reference mode wrong");
  chk_diff_drivers: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (conv_q && REF_DIFF_O && (X_DRV_O || Y_DRV_O)) |=> (!conv_q || load_q || X_DRV_O || Y_DRV_O))
    else $error("drivers dropped in differential mode");
  chk_xy_drivers: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (load_q && ctrl_q.channel_select_field == CH_XP) |-> Y_DRV_O && !X_DRV_O)
    else $error("wrong driver for X input");
  chk_power_mode: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    $rose(conv_q) |=> !POWER_DOWN_O)
    else $error("powered down while converting");
  chk_bad_combo: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (last_bit && !dec_valid) |=> !load_q && $stable(route_q))
    else $error("invalid word took effect");
  chk_spacing: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    conv_end |=> !conv_q && state_q != ST_CONV)
    else $error("word spacing not honoured");
endmodule
`default_nettype wire

// ### tb/tcd_host_model.sv
// Purpose: Host serial port that shifts control words into the decoder.
// Assumes: Serial clock idles low and runs only inside a frame, 64 ns period.
// Notes: Data changes just after each falling edge, well clear of the rise.
`default_nettype none
module tcd_host_model (
  // Serial link toward the decoder
  output logic sclk_o,
  output logic sdata_o,
  output logic cs_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Idle state
  // ------------------------------------------------------------
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    cs_b_o = 1'b1;
  end
  // Shift n bits, bits[n-1] first; the 13 ns lead keeps phase unrelated to MCLK.
  task automatic frame(input logic [63:0] bits, input int n);
    cs_b_o = 1'b0;
    #13;
    for (int i = n - 1; i >= 0; i--) begin
      #2 sdata_o = bits[i];
      #30 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #20 cs_b_o = 1'b1;
    // A released line must not keep its last value, so it is inverted.
    sdata_o = ~sdata_o;
  endtask
endmodule
`default_nettype wire

// ### tb/tcd_decoder_tb.sv
// Purpose: Self-checking bench for the serial control word decoder.
// Assumes: State byte is {mux, x drv, y drv, ref diff, 8-bit, irq en}.
// Notes: Every frame starts with six zeros that must be ignored.
`default_nettype none
module tcd_decoder_tb;
  import tcd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic sclk, sdata, cs_b, x_drv, y_drv, ref_diff, res8, start, conv, pdn, irq_en, loaded;
  tcd_mux_t mux;
  int fails = 0, checks = 0, pulses = 0, np = 0, cyc = 0;
  logic [7:0] st;
  logic [7:0] pw;
  logic [7:0] wtab [6] = '{8'h97, 8'hA7, 8'hD7, 8'hE7, 8'hD3, 8'hE3};
  logic [7:0] etab [6] = '{8'h20, 8'h60, 8'h40, 8'h80, 8'h54, 8'hA4};
  logic [7:0] ptab [3] = '{8'h01, 8'h01, 8'h00};
  // ------------------------------------------------------------
  // Design, host and observation
  // ------------------------------------------------------------
  tcd_host_model host (.sclk_o(sclk), .sdata_o(sdata), .cs_b_o(cs_b));
  tcd_decoder DUT (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .SERIAL_CONVERSION_CLOCK_I(sclk),
    .SDATA_I(sdata), .CS_B_I(cs_b), .MUX_SEL_O(mux), .X_DRV_O(x_drv), .Y_DRV_O(y_drv),
    .REF_DIFF_O(ref_diff), .RES_8BIT_O(res8), .CONV_START_O(start), .CONVERTING_O(conv),
    .POWER_DOWN_O(pdn), .TOUCH_DETECT_IRQ_EN_O(irq_en), .WORD_LOADED_O(loaded));
  assign st = {mux, x_drv, y_drv, ref_diff, res8, irq_en};
  assign pw = {6'h00, conv, pdn};
  always #4 MCLK_I = ~MCLK_I;
  // Load pulses are counted so a missing or doubled load shows up.
  always @(posedge MCLK_I) begin
    if (start === 1'b1 && loaded === 1'b1) pulses <= pulses + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Frames end with the serial clock still, then outputs get time to settle.
  task automatic send(input logic [63:0] bits, input int n, input int loads);
    host.frame(bits, n);
    repeat (10) @(posedge MCLK_I);
    #1;
    np += loads;
    chk("load pulses", 8'(np), 8'(pulses));
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge MCLK_I);
    #1 RST_B_I = 1'b1;
    repeat (4) @(posedge MCLK_I);
    #1;
    chk("reset state", 8'h01, st);
    chk("reset power", 8'h00, pw);
    // X position, differential, still converting after two more rises.
    send({8'h93, 2'b00}, 16, 1);
    chk("x diff", 8'h2C, st);
    chk("x diff power", 8'h02, pw);
    for (int i = 0; i < 6; i++) begin
      send({wtab[i], 2'b00}, 16, 1);
      chk("route table", etab[i], st);
    end
    send({8'h87, 2'b00}, 16, 0);
    chk("invalid kept", 8'hA4, st);
    for (int i = 0; i < 3; i++) begin
      send({6'h2B, 2'(i), 8'h00}, 22, 1);
      chk("power irq", 8'h63 - 8'(i % 2), st);
      chk("power mode", ptab[i], pw);
    end
    send({8'hAF, 2'b00, 8'hDF, 2'b00}, 26, 2);
    chk("overlap 8", 8'h42, st);
    send({8'hA7, 6'h00, 8'hE7, 2'b00}, 30, 2);
    chk("overlap 12", 8'h80, st);
    stop_test();
  end
endmodule
`default_nettype wire
